// file: core/sfcfg_device.sv
// flash device end: configuration register, status write and lock modes
`timescale 1ns/10ps
`default_nettype none
module sfcfg_device #(
    parameter int unsigned WRITE_CYCLES = sfcfg_pkg::STATUS_WRITE_CYCLES
) (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    // serial link
    sfcfg_link_if.device    link,
    // mode input from the array logic
    input  wire logic       i_four_wire_mode,
    // program/erase request
    input  wire logic       i_pe_req,
    input  wire logic       i_pe_in_region,
    output logic            o_pe_grant,
    output logic            o_pe_refused,
    // register views
    output logic [7:0]      o_status,
    output logic [7:0]      o_config,
    output logic            o_hard_lock,
    // dummy clock counts
    output logic [3:0]      o_dummy_fast,
    output logic [3:0]      o_dummy_dual_io,
    output logic [3:0]      o_dummy_quad_io
);
    // pin synchronisers
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [1:0]  mosi_s;
    logic [1:0]  wp_s;
    // link state
    logic [4:0]  bit_cnt;
    logic [2:0]  byte_phase;
    logic [23:0] rx_sh;
    logic [7:0]  tx_sh;
    logic [1:0]  read_sel;
    logic        miso_q;
    // status register
    logic        status_lock;
    logic        quad_io_enable;
    logic [3:0]  protect_level;
    logic        write_latch;
    logic        write_busy;
    // configuration register
    logic [1:0]  dummy_count_sel;
    logic        wide_address_flag;
    logic        protect_from_low_end;
    logic [2:0]  drive_strength_sel;
    // self-timed write
    logic [31:0] busy_cnt;
    logic [7:0]  stage_sr;
    logic [7:0]  stage_cr;
    logic        stage_cr_valid;

    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_rise;
    logic        cs_fall;
    logic        cs_low;
    logic        mosi_in;
    logic        wp_high;
    logic        hard_lock;
    logic [23:0] next_rx;
    logic [7:0]  status_value;
    logic [7:0]  config_value;
    logic        write_status_cmd_len_ok;
    logic        write_status_cmd_ok;
    logic        busy_done;

    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall = ~sclk_s[1] & sclk_s[2];
    assign cs_rise   = cs_s[1] & ~cs_s[2];
    assign cs_fall   = ~cs_s[1] & cs_s[2];
    assign cs_low    = ~cs_s[1];
    assign mosi_in   = mosi_s[1];
    assign wp_high   = wp_s[1];
    assign next_rx   = {rx_sh[22:0], mosi_in};

    // four-wire mode or quad enable turn the pin into data
    assign hard_lock = status_lock & ~wp_high & ~quad_io_enable
                       & ~i_four_wire_mode;

    assign status_value = {status_lock, quad_io_enable, protect_level,
                           write_latch, write_busy};
    assign config_value = {dummy_count_sel, wide_address_flag, sfcfg_pkg::CR_RSVD_VALUE,
                           protect_from_low_end, drive_strength_sel};

    assign write_status_cmd_len_ok = (bit_cnt == sfcfg_pkg::BITS_ONE_BYTE) ||
                         (bit_cnt == sfcfg_pkg::BITS_TWO_BYTE);
    assign write_status_cmd_ok = cs_rise && write_status_cmd_len_ok && write_latch
                     && !write_busy && !hard_lock
                     && (bit_cnt == sfcfg_pkg::BITS_ONE_BYTE
                         ? rx_sh[15:8] : rx_sh[23:16]) == sfcfg_pkg::OP_WRITE_STAT;
    assign busy_done = write_busy && (busy_cnt == 32'h0000_0001);

    function automatic logic [1:0] read_select(input logic [7:0] op);
        logic [1:0] s;
        s = 2'h0;
        if (op == sfcfg_pkg::OP_READ_STAT) begin
            s = 2'h1;
        end else if (op == sfcfg_pkg::OP_READ_CFG) begin
            s = 2'h2;
        end
        return s;
    endfunction

    // first stage feeds only the second
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_s <= 3'h0;
            cs_s   <= 3'h7;
            mosi_s <= 2'h0;
            wp_s   <= 2'h3;
        end else begin
            sclk_s <= {sclk_s[1:0], link.sclk};
            cs_s   <= {cs_s[1:0], link.cs_n};
            mosi_s <= {mosi_s[0], link.mosi};
            wp_s   <= {wp_s[0], link.wp_n};
        end
    end

    // receive side: count and shift on rising link clock
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt    <= 5'h00;
            byte_phase <= 3'h0;
            rx_sh      <= 24'h00_0000;
        end else if (cs_fall) begin
            bit_cnt    <= 5'h00;
            byte_phase <= 3'h0;
        end else if (cs_low && sclk_rise) begin
            rx_sh      <= next_rx;
            byte_phase <= byte_phase + 3'h1;
            if (bit_cnt != 5'h1F) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // transmit side: register reads, reloaded every byte so busy stays live
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_sh    <= 8'h00;
            read_sel <= 2'h0;
            miso_q   <= 1'b0;
        end else if (!cs_low) begin
            read_sel <= 2'h0;
            miso_q   <= 1'b0;
        end else if (sclk_rise && byte_phase == 3'h7) begin
            if (bit_cnt == 5'h07) begin
                read_sel <= read_select(next_rx[7:0]);
                tx_sh    <= (read_select(next_rx[7:0]) == 2'h1) ? status_value :
                            (read_select(next_rx[7:0]) == 2'h2) ? config_value : 8'h00;
            end else begin
                tx_sh <= (read_sel == 2'h1) ? status_value :
                         (read_sel == 2'h2) ? config_value : 8'h00;
            end
        end else if (sclk_fall) begin
            miso_q <= tx_sh[7];
            tx_sh  <= {tx_sh[6:0], 1'b0};
        end
    end

    assign link.miso = miso_q;

    // latch and busy; a latch set wins over any clear in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_latch <= 1'b0;
            write_busy  <= 1'b0;
            busy_cnt    <= 32'h0000_0000;
        end else begin
            if (write_status_cmd_ok) begin
                write_busy <= 1'b1;
                busy_cnt   <= WRITE_CYCLES;
            end else if (busy_done) begin
                write_busy  <= 1'b0;
                write_latch <= 1'b0;
                busy_cnt    <= 32'h0000_0000;
            end else if (write_busy) begin
                busy_cnt <= busy_cnt - 32'h0000_0001;
            end
            if (i_pe_req && o_pe_grant == 1'b0 && write_latch && !write_busy
                && !i_pe_in_region) begin
                write_latch <= 1'b0;
            end
            // latch may be set in either lock mode; hard lock blocks the write itself
            if (cs_rise && !write_busy && bit_cnt == sfcfg_pkg::BITS_OPCODE
                && rx_sh[7:0] == sfcfg_pkg::OP_LATCH_SET) begin
                write_latch <= 1'b1;
            end
        end
    end

    // staged data is applied when the timed cycle ends
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage_sr       <= 8'h00;
            stage_cr       <= 8'h00;
            stage_cr_valid <= 1'b0;
        end else if (write_status_cmd_ok) begin
            stage_sr       <= (bit_cnt == sfcfg_pkg::BITS_ONE_BYTE) ? rx_sh[7:0] : rx_sh[15:8];
            stage_cr       <= rx_sh[7:0];
            stage_cr_valid <= (bit_cnt == sfcfg_pkg::BITS_TWO_BYTE);
        end
    end

    // status bits; latch and busy are never taken from the data
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_lock    <= 1'b0;
            quad_io_enable <= 1'b0;
            protect_level  <= 4'h0;
        end else if (busy_done) begin
            status_lock    <= stage_sr[sfcfg_pkg::SR_LOCK_BIT];
            quad_io_enable <= stage_sr[sfcfg_pkg::SR_QUAD_BIT];
            protect_level  <= stage_sr[sfcfg_pkg::SR_LEVEL_LSB +: 4];
        end
    end

    // configuration bits
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dummy_count_sel      <= sfcfg_pkg::DUMMY_RESET;
            drive_strength_sel   <= sfcfg_pkg::DRIVE_RESET;
            protect_from_low_end <= 1'b0;
        end else if (busy_done && stage_cr_valid) begin
            dummy_count_sel <= stage_cr[sfcfg_pkg::CR_DUMMY_LSB +: 2];
            // reserved strength codes are dropped, the old code stays
            if (stage_cr[2:0] != sfcfg_pkg::DRIVE_RSVD_A
                && stage_cr[2:0] != sfcfg_pkg::DRIVE_RSVD_B) begin
                drive_strength_sel <= stage_cr[2:0];
            end
            // one-time programmable: can only go from 0 to 1
            protect_from_low_end <= protect_from_low_end
                                    | stage_cr[sfcfg_pkg::CR_LOW_BIT];
        end
    end

    // wide address flag follows only its own two commands
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wide_address_flag <= 1'b0;
        end else if (cs_rise && !write_busy && bit_cnt == sfcfg_pkg::BITS_OPCODE) begin
            if (rx_sh[7:0] == sfcfg_pkg::OP_WIDE_ENTER) begin
                wide_address_flag <= 1'b1;
            end else if (rx_sh[7:0] == sfcfg_pkg::OP_WIDE_EXIT) begin
                wide_address_flag <= 1'b0;
            end
        end
    end

    // program/erase gate
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pe_grant   <= 1'b0;
            o_pe_refused <= 1'b0;
        end else begin
            o_pe_grant   <= i_pe_req && !o_pe_grant && write_latch && !write_busy
                            && !i_pe_in_region;
            o_pe_refused <= i_pe_req && !o_pe_grant
                            && (!write_latch || write_busy || i_pe_in_region);
        end
    end

    // registered views
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_status        <= 8'h00;
            o_config        <= 8'h00;
            o_hard_lock     <= 1'b0;
            o_dummy_fast    <= 4'h0;
            o_dummy_dual_io <= 4'h0;
            o_dummy_quad_io <= 4'h0;
        end else begin
            o_status        <= status_value;
            o_config        <= config_value;
            o_hard_lock     <= hard_lock;
            o_dummy_fast    <= sfcfg_pkg::dummy_clocks(dummy_count_sel,
                                                       sfcfg_pkg::SFCFG_RD_FAST);
            o_dummy_dual_io <= sfcfg_pkg::dummy_clocks(dummy_count_sel,
                                                       sfcfg_pkg::SFCFG_RD_DUAL_IO);
            o_dummy_quad_io <= sfcfg_pkg::dummy_clocks(dummy_count_sel,
                                                       sfcfg_pkg::SFCFG_RD_QUAD_IO);
        end
    end
endmodule
`default_nettype wire

// file: core/sfcfg_pkg.sv
// shared constants for the flash configuration / status-write link
package sfcfg_pkg;
    // command codes
    localparam logic [7:0] OP_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_WRITE_STAT  = 8'h01;
    localparam logic [7:0] OP_READ_STAT   = 8'h05;
    localparam logic [7:0] OP_READ_CFG    = 8'h15;
    localparam logic [7:0] OP_WIDE_ENTER  = 8'hB7;
    localparam logic [7:0] OP_WIDE_EXIT   = 8'hE9;
    // status register layout
    localparam int SR_LOCK_BIT  = 7;
    localparam int SR_QUAD_BIT  = 6;
    localparam int SR_LEVEL_LSB = 2;
    localparam int SR_LATCH_BIT = 1;
    localparam int SR_BUSY_BIT  = 0;
    // configuration register layout
    localparam int CR_DUMMY_LSB = 6;
    localparam int CR_WIDE_BIT  = 5;
    localparam int CR_RSVD_BIT  = 4;
    localparam int CR_LOW_BIT   = 3;
    localparam logic       CR_RSVD_VALUE = 1'b0;
    localparam logic [2:0] DRIVE_RESET   = 3'h7;
    localparam logic [2:0] DRIVE_RSVD_A  = 3'h0;
    localparam logic [2:0] DRIVE_RSVD_B  = 3'h4;
    localparam logic [1:0] DUMMY_RESET   = 2'h0;
    // link bit counts that end an opcode-only command or a status write
    localparam logic [4:0] BITS_OPCODE   = 5'h08;
    localparam logic [4:0] BITS_ONE_BYTE = 5'h10;
    localparam logic [4:0] BITS_TWO_BYTE = 5'h18;
    // timing
    localparam int CLK_PERIOD_NS        = 5;
    localparam int STATUS_WRITE_TIME_NS = 10000;
    localparam int STATUS_WRITE_CYCLES  =
        (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LINK_PERIOD_NS       = 160;
    localparam int SCLK_HALF_CYCLES     = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // controller register offsets
    localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
    localparam logic [7:0] HOST_DATA_OFS = 8'h04;
    localparam logic [7:0] HOST_RX_OFS   = 8'h08;
    localparam logic [7:0] HOST_STAT_OFS = 8'h0C;
    localparam logic [7:0] HOST_CTRL_OFS = 8'h10;

    typedef enum logic [1:0] {
        SFCFG_RD_FAST,
        SFCFG_RD_DUAL_IO,
        SFCFG_RD_QUAD_IO
    } sfcfg_read_kind_t;

    // dummy clocks per read kind and dummy_count_sel
    function automatic logic [3:0] dummy_clocks(input logic [1:0] sel,
                                                input sfcfg_read_kind_t kind);
        logic [3:0] n;
        n = 4'h8;
        case (sel)
            2'h0: n = (kind == SFCFG_RD_DUAL_IO) ? 4'h4 :
                      (kind == SFCFG_RD_QUAD_IO) ? 4'h6 : 4'h8;
            2'h1: n = (kind == SFCFG_RD_QUAD_IO) ? 4'h4 : 4'h6;
            2'h2: n = 4'h8;
            default: n = 4'hA;
        endcase
        return n;
    endfunction
endpackage

// file: core/sfcfg_link_if.sv
// serial link between the flash controller and the flash device
`timescale 1ns/10ps
`default_nettype none
interface sfcfg_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic wp_n;

    modport host (output sclk, output cs_n, output mosi, output wp_n, input miso);
    modport device (input sclk, input cs_n, input mosi, input wp_n, output miso);
endinterface
`default_nettype wire

// file: core/sfcfg_host.sv
// flash controller end: apb command registers driving the serial link
`timescale 1ns/10ps
`default_nettype none
module sfcfg_host #(
    parameter int unsigned HALF_CYCLES = sfcfg_pkg::SCLK_HALF_CYCLES
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // serial link
    sfcfg_link_if.host       link
);
    typedef enum logic [1:0] {SFCFG_IDLE, SFCFG_SHIFT, SFCFG_END} sfcfg_host_state_t;

    sfcfg_host_state_t state;
    logic [7:0]  div;
    logic [23:0] tx_sh;
    logic [5:0]  nbits;
    logic [5:0]  cnt;
    logic [7:0]  rx;
    logic [15:0] data;
    logic        wp_level;
    logic        sclk_q;
    logic        cs_n_q;
    logic        mosi_q;
    logic [1:0]  miso_s;
    logic        access;
    logic        start;
    logic        tick;
    logic        mapped;

    assign access = i_psel & i_penable & o_pready;
    assign start  = access & i_pwrite & (i_paddr == sfcfg_pkg::HOST_CMD_OFS)
                    & (state == SFCFG_IDLE);
    assign tick   = (div == 8'(HALF_CYCLES - 1));
    assign mapped = (i_paddr == sfcfg_pkg::HOST_CMD_OFS) || (i_paddr == sfcfg_pkg::HOST_DATA_OFS)
                    || (i_paddr == sfcfg_pkg::HOST_RX_OFS) || (i_paddr == sfcfg_pkg::HOST_STAT_OFS)
                    || (i_paddr == sfcfg_pkg::HOST_CTRL_OFS);

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= i_psel & i_penable & ~o_pready;
            o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
            case (i_paddr)
                sfcfg_pkg::HOST_DATA_OFS: o_prdata <= {16'h0000, data};
                sfcfg_pkg::HOST_RX_OFS:   o_prdata <= {24'h00_0000, rx};
                sfcfg_pkg::HOST_STAT_OFS: o_prdata <= {31'h0000_0000, state != SFCFG_IDLE};
                sfcfg_pkg::HOST_CTRL_OFS: o_prdata <= {31'h0000_0000, wp_level};
                default:                  o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // software keeps the protect pin high over a locked write
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data     <= 16'h0000;
            wp_level <= 1'b1;
        end else if (access && i_pwrite) begin
            if (i_paddr == sfcfg_pkg::HOST_DATA_OFS) begin
                data <= i_pwdata[15:0];
            end
            if (i_paddr == sfcfg_pkg::HOST_CTRL_OFS) begin
                wp_level <= i_pwdata[0];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            miso_s <= 2'h0;
        end else begin
            miso_s <= {miso_s[0], link.miso};
        end
    end

    // select low, opcode, data, select high
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state  <= SFCFG_IDLE;
            div    <= 8'h00;
            tx_sh  <= 24'h00_0000;
            nbits  <= 6'h00;
            cnt    <= 6'h00;
            rx     <= 8'h00;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            mosi_q <= 1'b0;
        end else begin
            case (state)
                SFCFG_IDLE: begin
                    if (start) begin
                        // only whole bytes go out, so select rises on a byte edge
                        tx_sh  <= {i_pwdata[6:0], data[7:0], data[15:8], 1'b0};
                        mosi_q <= i_pwdata[7];
                        nbits  <= 6'h08 + {i_pwdata[9:8], 3'h0} + {2'h0, i_pwdata[10], 3'h0};
                        cnt    <= 6'h00;
                        div    <= 8'h00;
                        cs_n_q <= 1'b0;
                        state  <= SFCFG_SHIFT;
                    end
                end
                SFCFG_SHIFT: begin
                    div <= tick ? 8'h00 : div + 8'h01;
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                        rx     <= {rx[6:0], miso_s[1]};
                        cnt    <= cnt + 6'h01;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        if (cnt == nbits) begin
                            state <= SFCFG_END;
                        end else begin
                            mosi_q <= tx_sh[23];
                            tx_sh  <= {tx_sh[22:0], 1'b0};
                        end
                    end
                end
                SFCFG_END: begin
                    div <= tick ? 8'h00 : div + 8'h01;
                    if (tick) begin
                        cs_n_q <= 1'b1;
                        state  <= SFCFG_IDLE;
                    end
                end
                default: begin
                    state  <= SFCFG_IDLE;
                    cs_n_q <= 1'b1;
                end
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = mosi_q;
    assign link.wp_n = wp_level;
endmodule
`default_nettype wire

// file: verification/sfcfg_checker.sv
// assertions on the link and device register views
`timescale 1ns/10ps
`default_nettype none
module sfcfg_checker #(
    parameter int unsigned WRITE_CYCLES = 20
) (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    // link and register views
    input  wire logic       cs_n,
    input  wire logic [7:0] o_status,
    input  wire logic [7:0] o_config,
    input  wire logic       o_hard_lock
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    int unsigned busy_cnt;
    sequence s_write_done;
        $fell(o_status[0]);
    endsequence
    // counter, since the busy span is far beyond a repetition count
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) busy_cnt <= 0;
        else busy_cnt <= o_status[0] ? busy_cnt + 1 : 0;
    end
    a_busy_latch: assert property ($rose(o_status[0]) |-> o_status[1])
        else $error("busy without latch");
    a_busy_select: assert property ($rose(o_status[0]) |-> cs_n)
        else $error("busy with select low");
    a_busy_end: assert property (s_write_done |-> !o_status[1])
        else $error("latch kept after write");
    a_busy_length: assert property (s_write_done |-> busy_cnt == WRITE_CYCLES)
        else $error("busy length wrong");
    a_drive_end: assert property (($changed(o_config[2:0]) && $past(o_config[2:0]) != 3'h0)
        |-> s_write_done)
        else $error("drive changed outside write");
    a_low_once: assert property (!$fell(o_config[3]))
        else $error("low end bit cleared");
    a_rsvd_zero: assert property (o_config[4] == 1'b0)
        else $error("reserved bit set");
    a_hard_hold: assert property ((o_hard_lock && !$past(o_status[0])) |-> $stable(o_status[7:2]))
        else $error("locked bits changed");
endmodule
`default_nettype wire

// file: verification/serial_flash_config_and_write_protect_bench.sv
// self-checking bench for the flash status-write link
`timescale 1ns/10ps
`default_nettype none
module serial_flash_config_and_write_protect_bench;
    localparam int unsigned WC = 600;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        psel = 0;
    logic        pen = 0;
    logic        pw = 0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0000_0000;
    logic [31:0] prd, rd, d;
    logic        rdy, err, perr, hl;
    logic        fw = 0, pe_req = 0, pe_in = 0, pg, pr;
    logic [7:0]  dst, dcf, sr, cr, rx;
    logic [3:0]  df, dd, dq;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          seed = 32'h7d3d;
    always #2.5 clk = ~clk;
    sfcfg_link_if lnk ();
    sfcfg_host i_sfcfg_host (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(err), .link(lnk));
    sfcfg_device #(.WRITE_CYCLES(WC)) i_sfcfg_device (.i_clk_sys(clk), .i_rst_n(rst_n),
        .link(lnk), .i_four_wire_mode(fw), .i_pe_req(pe_req), .i_pe_in_region(pe_in),
        .o_pe_grant(pg), .o_pe_refused(pr), .o_status(dst), .o_config(dcf), .o_hard_lock(hl),
        .o_dummy_fast(df), .o_dummy_dual_io(dd), .o_dummy_quad_io(dq));
    sfcfg_checker #(.WRITE_CYCLES(WC)) i_sfcfg_checker (.i_clk_sys(clk), .i_rst_n(rst_n),
        .cs_n(lnk.cs_n), .o_status(dst), .o_config(dcf), .o_hard_lock(hl));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pwd <= v;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        rd = prd;
        perr = err;
        if (n >= 50) chk(32'h0, 32'h1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic op(input logic [10:0] c, input logic [15:0] v);
        int n;
        n = 0;
        apb(1'b1, sfcfg_pkg::HOST_DATA_OFS, {16'h0, v});
        apb(1'b1, sfcfg_pkg::HOST_CMD_OFS, {21'h0, c});
        do begin
            apb(1'b0, sfcfg_pkg::HOST_STAT_OFS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 300);
        apb(1'b0, sfcfg_pkg::HOST_RX_OFS, 32'h0);
        rx = rd[7:0];
    endtask
    // status and config readback, dummy counts from the table
    task automatic regs();
        op({3'b100, sfcfg_pkg::OP_READ_STAT}, 16'h0);
        chk(32'(rx), 32'(sr));
        op({3'b100, sfcfg_pkg::OP_READ_CFG}, 16'h0);
        chk(32'(rx), 32'(cr));
        case (cr[7:6])
            2'h0: chk(32'({df, dd, dq}), 32'h846);
            2'h1: chk(32'({df, dd, dq}), 32'h664);
            2'h2: chk(32'({df, dd, dq}), 32'h888);
            default: chk(32'({df, dd, dq}), 32'hAAA);
        endcase
    endtask
    // latch, write, then an early status read whose busy bit must match ok
    task automatic wr(input logic [15:0] v, input logic [1:0] nb, input logic ok);
        int n;
        n = 0;
        op({3'b000, sfcfg_pkg::OP_LATCH_SET}, 16'h0);
        op({1'b0, nb, sfcfg_pkg::OP_WRITE_STAT}, v);
        op({3'b100, sfcfg_pkg::OP_READ_STAT}, 16'h0);
        chk(32'(rx[0]), 32'(ok));
        while (rx[0] !== 1'b0 && n < 20) begin
            op({3'b100, sfcfg_pkg::OP_READ_STAT}, 16'h0);
            n++;
        end
    endtask
    // one-cycle program/erase request, answer looked at on the edge after it
    task automatic pe(input logic r, input logic [1:0] e);
        pe_in <= r;
        pe_req <= 1'b1;
        @(posedge clk);
        pe_req <= 1'b0;
        @(posedge clk);
        chk(32'({pg, pr}), 32'(e));
    endtask
    function automatic logic [7:0] ecfg(input logic [7:0] o, input logic [7:0] v);
        logic [2:0] s;
        s = (v[2:0] == 3'h0 || v[2:0] == 3'h4) ? o[2:0] : v[2:0];
        return {v[7:6], o[5], 1'b0, o[3] | v[3], s};
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        sr = 8'h00;
        cr = 8'h07;
        regs();
        apb(1'b0, 8'h20, 32'h0);
        chk({perr, rd[30:0]}, 32'h8000_0000);
        op({3'b010, sfcfg_pkg::OP_WRITE_STAT}, 16'h00FC);
        regs();
        op({3'b000, sfcfg_pkg::OP_LATCH_SET}, 16'h0);
        op({3'b000, sfcfg_pkg::OP_WRITE_STAT}, 16'h0);
        sr = 8'h02;
        regs();
        op({3'b000, sfcfg_pkg::OP_WIDE_ENTER}, 16'h0);
        cr[5] = 1'b1;
        regs();
        op({3'b000, sfcfg_pkg::OP_WIDE_EXIT}, 16'h0);
        cr[5] = 1'b0;
        regs();
        $display("test basic done");
        for (int i = 0; i < 5; i++) begin
            // fixed corners first: reserved drive code, then dummy codes 01 and 11
            d = (i == 0) ? 32'h0000_0403 : (i == 1) ? 32'h0000_4100 :
                (i == 2) ? 32'h0000_C500 : $random(seed);
            wr(d[15:0], 2'h2, 1'b1);
            sr = {d[7:2], 2'b00};
            cr = ecfg(cr, d[15:8]);
            regs();
        end
        wr(16'h003F, 2'h1, 1'b1);
        sr = 8'h3C;
        regs();
        $display("test random done");
        wr(16'h0080, 2'h1, 1'b1);
        apb(1'b1, sfcfg_pkg::HOST_CTRL_OFS, 32'h0);
        wr(16'h0000, 2'h1, 1'b0);
        chk(32'(hl), 32'h1);
        sr = 8'h82;
        regs();
        apb(1'b1, sfcfg_pkg::HOST_CTRL_OFS, 32'h1);
        wr(16'h00C0, 2'h1, 1'b1);
        apb(1'b1, sfcfg_pkg::HOST_CTRL_OFS, 32'h0);
        wr(16'h0000, 2'h1, 1'b1);
        sr = 8'h00;
        regs();
        apb(1'b1, sfcfg_pkg::HOST_CTRL_OFS, 32'h1);
        wr(16'h0080, 2'h1, 1'b1);
        fw <= 1'b1;
        apb(1'b1, sfcfg_pkg::HOST_CTRL_OFS, 32'h0);
        wr(16'h0000, 2'h1, 1'b1);
        chk(32'(hl), 32'h0);
        fw <= 1'b0;
        pe(1'b0, 2'b01);
        op({3'b000, sfcfg_pkg::OP_LATCH_SET}, 16'h0);
        pe(1'b1, 2'b01);
        pe(1'b0, 2'b10);
        regs();
        $display("test lock done");
        end_sim();
    end
    // limit well beyond the expected run of about 41k cycles
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
